// ---- logic/its_pkg.sv ----
// constants, types and helpers shared by the ignition timing supervisor
// assumes one 50 MHz clock domain; angles are signed tenths of a crank degree
package its_pkg;

  // angle and speed widths
  localparam int ANG_W = 12;
  localparam int WIDE_W = ANG_W + 3;
  localparam int RPM_W = 16;
  localparam int LOOP_W = 10;
  localparam int MIS_W = 8;
  localparam int CURVE_PTS = 5;
  localparam int CYL_N = 16;
  localparam int CYL_W = 4;

  typedef logic signed [ANG_W-1:0] its_ang_t;
  typedef logic signed [WIDE_W-1:0] its_wide_t;
  typedef logic [RPM_W-1:0] its_rpm_t;

  // angle scaling and limits
  localparam int ANG_PER_DEG = 10;
  localparam int SPAN_DEG = 38;
  localparam int CYL_TRIM_DEG = 2;
  localparam its_ang_t ANG_SPAN = its_ang_t'(SPAN_DEG * ANG_PER_DEG);
  localparam its_ang_t CYL_TRIM_MAX = its_ang_t'(CYL_TRIM_DEG * ANG_PER_DEG);

  // ignition energy range in percent
  localparam logic [6:0] ENERGY_MIN_PCT = 7'h0F;
  localparam logic [6:0] ENERGY_MAX_PCT = 7'h64;

  // fault flag positions and reset values
  localparam int FLT_OVERSPEED = 0;
  localparam int FLT_PICKUP = 1;
  localparam int FLT_LOW_VOLT = 2;
  localparam int FLT_MISFIRE = 3;
  localparam logic [3:0] RST_FAULTS = 4'h0;
  localparam logic [MIS_W-1:0] RST_MIS_CNT = 8'h00;
  localparam its_ang_t RST_ANGLE = 12'h000;

  // supervisor states and digital input functions
  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_HOLD} its_state_t;
  typedef enum logic {DIG_SCHED_SEL, DIG_RUN_STOP} its_dig_mode_t;

  // saturate a wide angle into [lo, hi]; lo wins if the window is inverted
  function automatic its_ang_t ang_clamp(its_wide_t v, its_ang_t lo, its_ang_t hi);
    its_ang_t r;
    if (v > its_wide_t'(hi)) begin
      r = hi;
    end else begin
      r = its_ang_t'(v);
    end
    if (v < its_wide_t'(lo) || hi < lo) begin
      r = lo;
    end
    return r;
  endfunction

endpackage

// ---- logic/its_timing_if.sv ----
// bundle between the supervisor and the firing-angle calculator
// assumes the supervisor drives every setting and reads back the angle
`timescale 1ns/1ps
interface its_timing_if;
  import its_pkg::*;
  logic sched_b; // second schedule active
  its_ang_t base; // base timing
  logic pot_en; // manual knob enabled
  its_ang_t pot_val; // manual knob reading
  its_ang_t pot_min;
  its_ang_t pot_max;
  logic [LOOP_W-1:0] loop_code; // 0 = 4 mA, full scale = 20 mA
  its_ang_t ana_lo; // offset at 4 mA
  its_ang_t ana_hi; // offset at 20 mA
  logic [1:0] ana_en; // per schedule
  logic [1:0] curve_en; // per schedule
  its_ang_t [1:0] lim_min; // per schedule
  its_ang_t [1:0] lim_max; // per schedule
  its_ang_t b_off; // second schedule offset
  its_rpm_t rpm;
  its_rpm_t [CURVE_PTS-1:0] curve_rpm;
  its_ang_t [CURVE_PTS-1:0] curve_ang;
  logic cyl_en;
  its_ang_t cyl_trim; // trim of the cylinder being fired
  its_ang_t angle; // resulting firing angle

  modport sup (output sched_b, base, pot_en, pot_val, pot_min, pot_max, loop_code,
    ana_lo, ana_hi, ana_en, curve_en, lim_min, lim_max, b_off, rpm, curve_rpm,
    curve_ang, cyl_en, cyl_trim, input angle);
  modport calc (input sched_b, base, pot_en, pot_val, pot_min, pot_max, loop_code,
    ana_lo, ana_hi, ana_en, curve_en, lim_min, lim_max, b_off, rpm, curve_rpm,
    curve_ang, cyl_en, cyl_trim, output angle);
endinterface

// ---- logic/its_timing_calc.sv ----
// firing-angle composition: sum of enabled corrections, clamped per schedule
// assumes settings are stable for a cycle; purely combinational
`timescale 1ns/1ps
module its_timing_calc
  import its_pkg::*;
(
  // settings in, angle out
  its_timing_if.calc tif
);

  logic sel; // active schedule index
  its_ang_t lo; // active lower limit
  its_ang_t hi; // upper limit confined to the span
  its_ang_t pot; // bounded knob term
  its_ang_t ana; // loop-current term
  its_ang_t crv; // speed-curve term
  its_ang_t trim; // bounded cylinder term
  its_wide_t sum; // unclamped total
  logic signed [WIDE_W+LOOP_W:0] prod; // scaled loop product

  //////////////////////////////////////////////////////////////////////////
  // speed curve lookup: step to the highest point already passed
  // points are taken as ascending; a step curve avoids a divider
  function automatic its_ang_t curve_pick(its_rpm_t rpm, its_rpm_t [CURVE_PTS-1:0] pr,
                                          its_ang_t [CURVE_PTS-1:0] pa);
    its_ang_t r;
    r = RST_ANGLE;
    for (int i = 0; i < CURVE_PTS; i++) begin
      if (rpm >= pr[i]) begin
        r = pa[i];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // angle composition
  always_comb begin
    sel = tif.sched_b;
    lo = tif.lim_min[sel];
    // window never wider than the total span
    hi = ang_clamp(its_wide_t'(tif.lim_max[sel]), lo,
                   ang_clamp(its_wide_t'(lo) + its_wide_t'(ANG_SPAN), lo,
                             its_ang_t'({1'b0, {(ANG_W-1){1'b1}}})));
    pot = tif.pot_en ? ang_clamp(its_wide_t'(tif.pot_val), tif.pot_min, tif.pot_max)
                     : RST_ANGLE;
    // linear map across the loop range
    prod = (WIDE_W+LOOP_W+1)'((its_wide_t'(tif.ana_hi) - its_wide_t'(tif.ana_lo))
           * $signed({1'b0, tif.loop_code}));
    ana = its_ang_t'(its_wide_t'(tif.ana_lo) + its_wide_t'(prod >>> LOOP_W));
    crv = curve_pick(tif.rpm, tif.curve_rpm, tif.curve_ang);
    trim = tif.cyl_en ? ang_clamp(its_wide_t'(tif.cyl_trim), -CYL_TRIM_MAX, CYL_TRIM_MAX)
                      : RST_ANGLE;
    sum = its_wide_t'(tif.base) + its_wide_t'(pot)
        + (tif.ana_en[sel] ? its_wide_t'(ana) : its_wide_t'(0))
        + (tif.curve_en[sel] ? its_wide_t'(crv) : its_wide_t'(0))
        + (sel ? its_wide_t'(tif.b_off) : its_wide_t'(0))
        + its_wide_t'(trim);
    tif.angle = ang_clamp(sum, lo, hi);
  end

endmodule

// ---- logic/its_supervisor.sv ----
// ignition timing supervisor: mode select, fault shutdown, restart guard,
// misfire rate check, energy setting and firing angle output
// assumes all inputs are synchronous to i_sys_clk and settings are quasi static
//
// Summary of operation
// - permit output conducts only while firing
// - four faults shut the ignition outputs down
// - remote mode: closed input stops ignition
// - remote mode uses first schedule only
// - stop above security speed blocks until standstill
// - select mode: closed picks second schedule
// - each schedule own limits, enables; second has offset
// - total adjustment confined to 38 degrees
// - manual knob bounded, ignored when deactivated
// - loop current maps linearly to bounded offset
// - speed curve of up to five points
// - per-cylinder trim at most 2 degrees
// - misfires per cycle over rate stop ignition
// - energy 15 to 100 percent, scales spark
// - pickup errors shown on status indicator
`timescale 1ns/1ps
module its_supervisor
  import its_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // digital input
  input wire its_dig_mode_t i_dig_mode,
  input wire logic i_dig_closed,
  // fault sources
  input wire logic i_overspeed,
  input wire logic i_pickup_err,
  input wire logic i_low_volt,
  input wire logic i_fault_clear,
  // misfire detection
  input wire logic i_open_circ,
  input wire logic i_cycle_end,
  input wire logic [MIS_W-1:0] i_misfire_limit,
  // speed
  input wire its_rpm_t i_rpm,
  input wire its_rpm_t i_security_rpm,
  // timing settings
  input wire its_ang_t i_base_ang,
  input wire logic i_pot_en,
  input wire its_ang_t i_pot_val,
  input wire its_ang_t i_pot_min,
  input wire its_ang_t i_pot_max,
  input wire logic [LOOP_W-1:0] i_loop_code,
  input wire its_ang_t i_ana_lo,
  input wire its_ang_t i_ana_hi,
  input wire logic [1:0] i_ana_en,
  input wire logic [1:0] i_curve_en,
  input wire its_ang_t [1:0] i_lim_min,
  input wire its_ang_t [1:0] i_lim_max,
  input wire its_ang_t i_b_offset,
  input wire its_rpm_t [CURVE_PTS-1:0] i_curve_rpm,
  input wire its_ang_t [CURVE_PTS-1:0] i_curve_ang,
  input wire logic i_cyl_en,
  input wire logic [CYL_W-1:0] i_cyl_idx,
  input wire its_ang_t [CYL_N-1:0] i_cyl_trim,
  // energy
  input wire logic [6:0] i_energy_pct,
  // outputs
  output logic o_ign_enable,
  output logic o_firing_permit_output,
  output logic o_sched_b,
  output its_ang_t o_fire_angle,
  output logic [6:0] o_energy_pct,
  output logic o_pickup_led,
  output logic [3:0] o_fault_flags,
  output logic o_restart_blocked,
  output logic o_loop_supply_output
);

  its_timing_if tif ();

  its_state_t state_q, state_d; // supervisor state
  logic [3:0] faults_q, faults_d; // latched fault causes
  logic [MIS_W-1:0] mis_cnt_q, mis_cnt_d; // misfires this cycle
  logic [MIS_W:0] mis_tot; // count including this cycle's event
  logic mis_trip; // rate exceeded at cycle end
  logic stop_req; // remote stop asserted
  logic ign_d, permit_d, sched_b_d, pu_led_d, blocked_d;
  its_ang_t angle_d;
  logic [6:0] energy_d;

  //////////////////////////////////////////////////////////////////////////
  // settings into the calculator; schedule comes from the flop, so the
  // angle lags a schedule change by one cycle
  assign tif.sched_b = o_sched_b;
  assign tif.base = i_base_ang;
  assign tif.pot_en = i_pot_en;
  assign tif.pot_val = i_pot_val;
  assign tif.pot_min = i_pot_min;
  assign tif.pot_max = i_pot_max;
  assign tif.loop_code = i_loop_code;
  assign tif.ana_lo = i_ana_lo;
  assign tif.ana_hi = i_ana_hi;
  assign tif.ana_en = i_ana_en;
  assign tif.curve_en = i_curve_en;
  assign tif.lim_min = i_lim_min;
  assign tif.lim_max = i_lim_max;
  assign tif.b_off = i_b_offset;
  assign tif.rpm = i_rpm;
  assign tif.curve_rpm = i_curve_rpm;
  assign tif.curve_ang = i_curve_ang;
  assign tif.cyl_en = i_cyl_en;
  assign tif.cyl_trim = i_cyl_trim[i_cyl_idx];

  its_timing_calc u_calc (
    .tif(tif.calc)
  );

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    // misfire count over one engine cycle
    mis_tot = {1'b0, mis_cnt_q} + {{MIS_W{1'b0}}, i_open_circ};
    mis_trip = i_cycle_end && (mis_tot > {1'b0, i_misfire_limit});
    if (i_cycle_end) begin
      mis_cnt_d = RST_MIS_CNT;
    end else if (i_open_circ && mis_cnt_q != {MIS_W{1'b1}}) begin
      mis_cnt_d = mis_tot[MIS_W-1:0]; // saturates rather than wrapping
    end else begin
      mis_cnt_d = mis_cnt_q;
    end
    // faults latch; a new event wins over a clear in the same cycle
    faults_d = faults_q & ~{4{i_fault_clear}};
    faults_d[FLT_OVERSPEED] = faults_d[FLT_OVERSPEED] | i_overspeed;
    faults_d[FLT_PICKUP] = faults_d[FLT_PICKUP] | i_pickup_err;
    faults_d[FLT_LOW_VOLT] = faults_d[FLT_LOW_VOLT] | i_low_volt;
    faults_d[FLT_MISFIRE] = faults_d[FLT_MISFIRE] | mis_trip;
    stop_req = (i_dig_mode == DIG_RUN_STOP) && i_dig_closed;
    // run/stop sequencing
    state_d = state_q;
    unique case (state_q)
      ST_OFF: begin
        if (!(|faults_d) && !stop_req) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if ((|faults_d) || stop_req) begin
          // fast switch-off must wait for standstill before restart
          state_d = (i_rpm > i_security_rpm) ? ST_HOLD : ST_OFF;
        end
      end
      ST_HOLD: begin
        if (i_rpm == '0) begin
          state_d = ST_OFF;
        end
      end
    endcase
    ign_d = (state_d == ST_RUN);
    permit_d = (state_d == ST_RUN);
    blocked_d = (state_d == ST_HOLD);
    // remote mode forces the first schedule
    sched_b_d = (i_dig_mode == DIG_SCHED_SEL) && i_dig_closed;
    pu_led_d = faults_d[FLT_PICKUP];
    angle_d = tif.angle;
    // out-of-range settings saturate into the accepted range
    if (i_energy_pct < ENERGY_MIN_PCT) begin
      energy_d = ENERGY_MIN_PCT;
    end else if (i_energy_pct > ENERGY_MAX_PCT) begin
      energy_d = ENERGY_MAX_PCT;
    end else begin
      energy_d = i_energy_pct;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers; every output comes from here
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q <= ST_OFF;
      faults_q <= RST_FAULTS;
      mis_cnt_q <= RST_MIS_CNT;
      o_ign_enable <= 1'b0;
      o_firing_permit_output <= 1'b0;
      o_sched_b <= 1'b0;
      o_fire_angle <= RST_ANGLE;
      o_energy_pct <= ENERGY_MAX_PCT;
      o_pickup_led <= 1'b0;
      o_fault_flags <= RST_FAULTS;
      o_restart_blocked <= 1'b0;
      o_loop_supply_output <= 1'b0;
    end else begin
      state_q <= state_d;
      faults_q <= faults_d;
      mis_cnt_q <= mis_cnt_d;
      o_ign_enable <= ign_d;
      o_firing_permit_output <= permit_d;
      o_sched_b <= sched_b_d;
      o_fire_angle <= angle_d;
      o_energy_pct <= energy_d;
      o_pickup_led <= pu_led_d;
      o_fault_flags <= faults_d;
      o_restart_blocked <= blocked_d;
      o_loop_supply_output <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence fast_stop_s;
    o_ign_enable && stop_req && (i_rpm > i_security_rpm);
  endsequence
  sequence over_rate_s;
    i_cycle_end && !i_open_circ && (mis_cnt_q > i_misfire_limit);
  endsequence

  permit_follows_a: assert property (o_firing_permit_output == o_ign_enable)
    else $error("permit differs from ignition enable");
  fault_stop_a: assert property ((i_overspeed || i_pickup_err || i_low_volt) |=>
    (!o_ign_enable && !o_firing_permit_output))
    else $error("fault did not stop ignition");
  remote_stop_a: assert property (stop_req |=> !o_ign_enable)
    else $error("remote stop ignored");
  remote_sched_a: assert property ((i_dig_mode == DIG_RUN_STOP) |=> !o_sched_b)
    else $error("second schedule in remote mode");
  restart_hold_a: assert property (fast_stop_s |=> o_restart_blocked ##0
    (!o_ign_enable throughout (o_restart_blocked [*2])) or (i_rpm == '0))
    else $error("restart guard not held");
  sched_select_a: assert property ((i_dig_mode == DIG_SCHED_SEL) |=>
    (o_sched_b == $past(i_dig_closed)))
    else $error("schedule select wrong");
  angle_span_a: assert property ((tif.angle >= i_lim_min[o_sched_b]) &&
    (its_wide_t'(tif.angle) <= its_wide_t'(i_lim_min[o_sched_b]) + its_wide_t'(ANG_SPAN)))
    else $error("angle outside span");
  misfire_trip_a: assert property (over_rate_s |=>
    (o_fault_flags[FLT_MISFIRE] && !o_ign_enable))
    else $error("misfire rate not acted on");
  energy_range_a: assert property ((o_energy_pct >= ENERGY_MIN_PCT) &&
    (o_energy_pct <= ENERGY_MAX_PCT))
    else $error("energy out of range");
  pickup_led_a: assert property (i_pickup_err |=> o_pickup_led ##1
    (o_pickup_led || $past(i_fault_clear)))
    else $error("pickup error not shown");
  remote_start_a: assert property ((state_q == ST_OFF && !stop_req && !(|faults_d))
    |=> o_ign_enable)
    else $error("ignition not re-enabled");

endmodule

// ---- verif/its_engine_model.sv ----
// crank-side partner: misfire pulses and engine cycle markers
// assumes the bench calls run_cycle and waits for it to return
`timescale 1ns/1ps
module its_engine_model (
  // clock
  input wire logic i_sys_clk,
  // misfire events toward the supervisor
  output logic o_open_circ,
  output logic o_cycle_end
);
  // quiet between cycles
  initial begin
    o_open_circ = 1'b0;
    o_cycle_end = 1'b0;
  end
  // n one-cycle misfire pulses, then the cycle marker
  task automatic run_cycle(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge i_sys_clk) o_open_circ = 1'b1;
      @(negedge i_sys_clk) o_open_circ = 1'b0;
    end
    @(negedge i_sys_clk) o_cycle_end = 1'b1;
    @(negedge i_sys_clk) o_cycle_end = 1'b0;
  endtask
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the ignition timing supervisor
// assumes 50 MHz clock, inputs driven on falling edges
`timescale 1ns/1ps
module tb_top;
  import its_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  its_dig_mode_t dig_mode = DIG_SCHED_SEL;
  logic closed = 1'b0, ovs = 1'b0, pku = 1'b0, lowv = 1'b0, clr = 1'b0;
  logic open_circ, cycle_end;
  logic [MIS_W-1:0] mis_lim = 8'h01;
  its_rpm_t rpm = 16'h0000, sec_rpm = 16'h07D0;
  its_ang_t base = 12'h064, pot_val = 12'h05A, pot_min = 12'hFCE, pot_max = 12'h032;
  logic pot_en = 1'b1, cyl_en = 1'b0;
  logic [LOOP_W-1:0] loop_code = 10'h200;
  its_ang_t ana_lo = 12'h000, ana_hi = 12'h0C8, b_off = 12'h028;
  logic [1:0] ana_en = 2'h0, curve_en = 2'h0;
  // lower limits leave room under the span cap for the correction sums
  its_ang_t [1:0] lim_min = {12'hFCE, 12'hFCE};
  its_ang_t [1:0] lim_max = {12'h258, 12'h258};
  its_rpm_t [CURVE_PTS-1:0] crv_rpm = {16'h1388, 16'h0FA0, 16'h0BB8, 16'h07D0, 16'h03E8};
  its_ang_t [CURVE_PTS-1:0] crv_ang = {12'h032, 12'h028, 12'h01E, 12'h014, 12'h00A};
  logic [CYL_W-1:0] cyl_idx = 4'h3;
  its_ang_t [CYL_N-1:0] cyl_trim = '0;
  logic [6:0] energy = 7'h32;
  logic [6:0] e_in [4] = '{7'h0A, 7'h0F, 7'h64, 7'h78};
  logic [6:0] e_out [4] = '{7'h0F, 7'h0F, 7'h64, 7'h64};
  logic ign, permit, sched_b, led, blocked, loop_pwr;
  its_ang_t angle;
  logic [6:0] energy_q;
  logic [3:0] flags;
  int failures = 0, samples_checked = 0;

  ////////////////////////////////////////////////////////////////
  // clock, partner and design
  always #10 clk = ~clk;
  its_engine_model its_engine_model_i (.i_sys_clk(clk), .o_open_circ(open_circ),
    .o_cycle_end(cycle_end));
  its_supervisor its_supervisor_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_dig_mode(dig_mode),
    .i_dig_closed(closed), .i_overspeed(ovs), .i_pickup_err(pku), .i_low_volt(lowv),
    .i_fault_clear(clr), .i_open_circ(open_circ), .i_cycle_end(cycle_end),
    .i_misfire_limit(mis_lim), .i_rpm(rpm), .i_security_rpm(sec_rpm), .i_base_ang(base),
    .i_pot_en(pot_en), .i_pot_val(pot_val), .i_pot_min(pot_min), .i_pot_max(pot_max),
    .i_loop_code(loop_code), .i_ana_lo(ana_lo), .i_ana_hi(ana_hi), .i_ana_en(ana_en),
    .i_curve_en(curve_en), .i_lim_min(lim_min), .i_lim_max(lim_max), .i_b_offset(b_off),
    .i_curve_rpm(crv_rpm), .i_curve_ang(crv_ang), .i_cyl_en(cyl_en), .i_cyl_idx(cyl_idx),
    .i_cyl_trim(cyl_trim), .i_energy_pct(energy), .o_ign_enable(ign),
    .o_firing_permit_output(permit), .o_sched_b(sched_b), .o_fire_angle(angle),
    .o_energy_pct(energy_q), .o_pickup_led(led), .o_fault_flags(flags),
    .o_restart_blocked(blocked), .o_loop_supply_output(loop_pwr));

  ////////////////////////////////////////////////////////////////
  // helpers: falling-edge stepping and comparisons
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_ang(input its_ang_t e);
    samples_checked++;
    if (angle !== e) begin
      failures++;
      $display("BAD angle expected %0d seen %0d", e, angle);
    end
  endtask
  task automatic chk_val(input string nm, input logic [6:0] e, input logic [6:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ignition and permit always move together
  task automatic chk_run(input logic e);
    chk_bit("ignition", e, ign);
    chk_bit("permit", e, permit);
  endtask
  // clear latched faults; restart comes on the same edge that takes the clear
  task automatic clear_faults();
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(1);
  endtask
  // one fault source pulsed, then cleared
  task automatic fault_case(input int b);
    {lowv, pku, ovs} = 3'(1 << b);
    step(1);
    {lowv, pku, ovs} = 3'h0;
    chk_run(1'b0);
    chk_val("faults", 7'(1 << b), {3'h0, flags});
    chk_bit("pickup led", b == 1, led);
    clear_faults();
    chk_run(1'b1);
  endtask
  // settle the two-stage angle path, then compare
  task automatic ang_case(input its_ang_t e);
    step(3);
    chk_ang(e);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // hang guard, far beyond the roughly seventy cycles needed
  initial begin
    #40000;
    failures++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    cyl_trim[3] = 12'hFBA;
    step(2);
    chk_run(1'b0);
    chk_val("energy", 7'h64, energy_q);
    chk_ang(12'h000);
    rst_n = 1'b1;
    step(1);
    chk_run(1'b1);
    chk_bit("loop supply", 1'b1, loop_pwr);
    for (int b = 0; b < 3; b++) begin
      fault_case(b);
    end
    its_engine_model_i.run_cycle(1);
    chk_run(1'b1);
    its_engine_model_i.run_cycle(2);
    chk_run(1'b0);
    chk_val("faults", 7'h08, {3'h0, flags});
    clear_faults();
    // remote stop and restart
    dig_mode = DIG_RUN_STOP;
    closed = 1'b1;
    step(1);
    chk_run(1'b0);
    ang_case(12'h096);
    chk_bit("schedule b", 1'b0, sched_b);
    closed = 1'b0;
    step(1);
    chk_run(1'b1);
    // stop above security speed holds until standstill
    rpm = 16'h0BB8;
    closed = 1'b1;
    step(1);
    chk_bit("blocked", 1'b1, blocked);
    closed = 1'b0;
    step(4);
    chk_run(1'b0);
    rpm = 16'h0000;
    step(2);
    chk_bit("blocked", 1'b0, blocked);
    chk_run(1'b1);
    // schedule select
    dig_mode = DIG_SCHED_SEL;
    closed = 1'b1;
    step(1);
    chk_bit("schedule b", 1'b1, sched_b);
    ang_case(12'h0BE);
    closed = 1'b0;
    ang_case(12'h096);
    // angle composition on schedule A, then on schedule B
    cyl_en = 1'b1;
    ang_case(12'h082);
    ana_en = 2'h1;
    ang_case(12'h0E6);
    rpm = 16'h05DC;
    curve_en = 2'h1;
    ang_case(12'h0F0);
    rpm = 16'h1388;
    ang_case(12'h118);
    pot_en = 1'b0;
    ang_case(12'h0E6);
    base = 12'h1F4;
    lim_min[0] = 12'hF9C;
    ang_case(12'h118);
    lim_min[1] = 12'h12C;
    closed = 1'b1;
    ang_case(12'h208);
    // energy saturation
    foreach (e_in[k]) begin
      energy = e_in[k];
      step(1);
      chk_val("energy", e_out[k], energy_q);
    end
    complete_run();
  end
endmodule
